// [design/mrsf_pkg.sv]
package mrsf_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_RETRY_COUNT   = 6'h19;
    localparam logic [5:0] IDX_RETRY_LIMIT   = 6'h2c;
    localparam logic [5:0] IDX_SEED_LOW      = 6'h2d;
    localparam logic [5:0] IDX_SEED_HIGH     = 6'h2e;
    localparam logic [5:0] IDX_MODE          = 6'h30;
    localparam logic [5:0] IDX_IRQ_STATUS    = 6'h31;
    localparam logic [5:0] IDX_IRQ_MASK      = 6'h32;
    localparam logic [5:0] IDX_TRANS_STATUS  = 6'h33;
    // reset values
    localparam logic [7:0] RST_RETRY_LIMIT   = 8'h38;
    localparam logic [7:0] RST_SEED_LOW      = 8'hea;
    localparam logic [7:0] RST_SEED_HIGH     = 8'h42;
    localparam logic [7:0] RST_MODE          = 8'h00;
    localparam logic [3:0] RST_IRQ_MASK      = 4'h0;
    localparam logic [10:0] RST_SEED         = 11'h2ea;
    // field positions
    localparam int FRAME_LIM_LSB = 4;
    localparam int CSMA_LIM_LSB  = 1;
    localparam int SLOT_BIT      = 0;
    localparam int FVN_LSB       = 6;
    localparam int SEED_HI_W     = 3;
    localparam int MODE_TX_BIT   = 0;
    localparam int MODE_RX_BIT   = 1;
    // special values
    localparam logic [2:0] CSMA_IMMEDIATE = 3'h7;
    localparam logic [1:0] FVN_ANY        = 2'h3;
    localparam logic [1:0] ACK_FVN        = 2'h0;
    // interrupt event bits
    localparam int EV_TX_OK   = 0;
    localparam int EV_TX_FAIL = 1;
    localparam int EV_ACK_PND = 2;
    localparam int EV_REJECT  = 3;
    localparam int EV_W       = 4;
    // transaction status codes
    localparam logic [2:0] TS_SUCCESS     = 3'h0;
    localparam logic [2:0] TS_ACK_PENDING = 3'h1;
    localparam logic [2:0] TS_ACCESS_FAIL = 3'h3;
    localparam logic [2:0] TS_NO_ACK      = 3'h5;
    localparam logic [2:0] TS_INVALID     = 3'h7;
    // transmit sequencer states
    typedef enum logic [1:0] {TX_IDLE, TX_CCA, TX_SEND, TX_WACK} mrsf_tx_state_t;
endpackage

// [design/mrsf_lfsr.sv]
`timescale 1ns/1ps
module mrsf_lfsr #(
    parameter int W = 11
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // seed load
    input  wire logic         load_in,
    input  wire logic [W-1:0] seed_in,
    // random value
    output logic      [W-1:0] rand_out
);
    logic [W-1:0] q_r;   // generator state
    logic [W-1:0] q_nxt; // next state

    // elaboration check: taps fit an 11-bit generator only
    if (W != 11) begin : g_chk
        $error("mrsf_lfsr supports W = 11 only");
    end

    // load seed or step; zero seed would lock up, so force one
    always_comb begin
        if (load_in) begin
            q_nxt = (seed_in == '0) ? W'(1) : seed_in;
        end else begin
            q_nxt = {q_r[W-2:0], q_r[W-1] ^ q_r[W-3]};
        end
    end

    // state register, reset to default seed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q_r <= 11'h2ea;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign rand_out = q_r;
endmodule // mrsf_lfsr

// [design/mrsf_top.sv]
`timescale 1ns/1ps
module mrsf_top
    import mrsf_pkg::*;
#(
    parameter int SEED_W = 11
) (
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RESET_N_IN,
    // wishbone slave
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [7:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    // host trigger pin
    input  wire logic        SLEEP_TX_TRIGGER_PIN_IN,
    // transmit side of the radio
    input  wire logic        TX_REQ_IN,
    input  wire logic        CCA_DONE_IN,
    input  wire logic        CCA_IDLE_IN,
    input  wire logic        TX_DONE_IN,
    input  wire logic        ACK_RCVD_IN,
    input  wire logic        ACK_TIMEOUT_IN,
    input  wire logic        DEEP_WAKE_IN,
    output logic             CCA_START_OUT,
    output logic             TX_START_OUT,
    output logic      [10:0] BACKOFF_RAND_OUT,
    // receive side of the radio
    input  wire logic        RX_DONE_IN,
    input  wire logic [1:0]  RX_VERSION_IN,
    input  wire logic        RX_ACK_REQ_IN,
    output logic             ACK_SEND_OUT,
    output logic      [1:0]  ACK_VERSION_OUT,
    output logic             RX_REJECT_OUT,
    // status and interrupt
    output logic      [2:0]  TRANSACTION_STATUS_OUT,
    output logic             IRQ_OUT
);
    // elaboration check on the seed width
    if (SEED_W != 8 + SEED_HI_W) begin : g_chk
        $error("mrsf_top needs SEED_W = 11");
    end

    // version acceptance, used by filter
    function automatic logic version_ok(input logic [1:0] ver, input logic [1:0] lim);
        version_ok = (lim == FVN_ANY) || (ver <= lim);
    endfunction

    // register file state
    logic [7:0]        limit_r, limit_nxt;     // retry_limit_control
    logic [7:0]        seed_lo_r, seed_lo_nxt; // backoff_seed_low
    logic [7:0]        seed_hi_r, seed_hi_nxt; // ack_filter_seed_high
    logic [7:0]        mode_r, mode_nxt;       // mode enables
    logic [EV_W-1:0]   irq_st_r, irq_st_nxt;   // sticky events
    logic [EV_W-1:0]   irq_mk_r, irq_mk_nxt;   // event mask
    logic              ack_r, ack_nxt;         // bus answer
    logic [31:0]       rdat_r, rdat_nxt;       // read data
    logic              irq_r, irq_nxt;         // interrupt line
    // transaction state
    mrsf_tx_state_t    st_r, st_nxt;           // sequencer state
    logic [3:0]        frm_cnt_r, frm_cnt_nxt; // frame_retry_count
    logic [2:0]        bo_cnt_r, bo_cnt_nxt;   // backoff_retry_count
    logic [3:0]        frm_lim_r, frm_lim_nxt; // latched frame limit
    logic [2:0]        bo_lim_r, bo_lim_nxt;   // latched backoff limit
    logic              pend_r, pend_nxt;       // ack waiting for trigger
    logic [2:0]        ts_r, ts_nxt;           // transaction_status
    logic              cca_go_r, cca_go_nxt;   // start channel access
    logic              tx_go_r, tx_go_nxt;     // start transmit
    logic              ack_go_r, ack_go_nxt;   // send acknowledgement
    logic              rej_r, rej_nxt;         // filter reject
    logic [1:0]        ackv_r, ackv_nxt;       // ack frame version
    logic [10:0]       rnd_r, rnd_nxt;         // sampled backoff random
    // pin synchroniser
    logic [2:0]        pin_sync_r;             // three stages
    logic              pin_lvl_r, pin_lvl_nxt; // agreed pin level
    // other nets
    logic [EV_W-1:0]   ev;                     // events this cycle
    logic [10:0]       rnd;                    // generator output
    logic              trig_rise;              // agreed rising edge
    logic              req;                    // new bus request
    logic [5:0]        idx;                    // register index

    assign req = WB_CYC_IN & WB_STB_IN & ~ack_r;
    assign idx = WB_ADR_IN[7:2];

    // backoff random generator, reloaded at deepest sleep wakeup
    mrsf_lfsr #(
        .W (SEED_W)
    ) u_rand (
        .clk      (CLK_IN),
        .reset_n  (RESET_N_IN),
        .load_in  (DEEP_WAKE_IN),
        .seed_in  ({seed_hi_r[SEED_HI_W-1:0], seed_lo_r}),
        .rand_out (rnd)
    );

    // pin stages; first stage feeds only the second
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            pin_sync_r <= 3'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], SLEEP_TX_TRIGGER_PIN_IN};
        end
    end

    // level changes once stages two and three agree
    always_comb begin
        pin_lvl_nxt = (pin_sync_r[1] == pin_sync_r[2]) ? pin_sync_r[2] : pin_lvl_r;
        trig_rise   = pin_lvl_nxt & ~pin_lvl_r;
    end

    // transaction sequencer and receive acknowledgement control
    always_comb begin
        st_nxt      = st_r;
        frm_cnt_nxt = frm_cnt_r;
        bo_cnt_nxt  = bo_cnt_r;
        frm_lim_nxt = frm_lim_r;
        bo_lim_nxt  = bo_lim_r;
        pend_nxt    = pend_r;
        ts_nxt      = ts_r;
        cca_go_nxt  = 1'b0;
        tx_go_nxt   = 1'b0;
        ack_go_nxt  = 1'b0;
        rej_nxt     = 1'b0;
        ackv_nxt    = ACK_FVN;
        rnd_nxt     = rnd_r;
        ev          = '0;
        unique case (st_r)
            // wait for a transmit request in auto-retry mode
            TX_IDLE: begin
                if (TX_REQ_IN && mode_r[MODE_TX_BIT]) begin
                    // limits latched here only
                    frm_lim_nxt = {1'b0, limit_r[FRAME_LIM_LSB +: 3]};
                    bo_lim_nxt  = limit_r[CSMA_LIM_LSB +: 3];
                    frm_cnt_nxt = 4'h0;
                    bo_cnt_nxt  = 3'h0;
                    if (limit_r[CSMA_LIM_LSB +: 3] == CSMA_IMMEDIATE) begin
                        tx_go_nxt = 1'b1;
                        st_nxt    = TX_SEND;
                    end else begin
                        cca_go_nxt = 1'b1;
                        rnd_nxt    = rnd;
                        st_nxt     = TX_CCA;
                    end
                end
            end
            // channel access with backoff retries
            TX_CCA: begin
                if (CCA_DONE_IN) begin
                    if (CCA_IDLE_IN) begin
                        tx_go_nxt = 1'b1;
                        st_nxt    = TX_SEND;
                    end else if (bo_cnt_r >= bo_lim_r) begin
                        ts_nxt        = TS_ACCESS_FAIL;
                        ev[EV_TX_FAIL] = 1'b1;
                        st_nxt        = TX_IDLE;
                    end else begin
                        bo_cnt_nxt = 3'(bo_cnt_r + 3'h1);
                        cca_go_nxt = 1'b1;
                        rnd_nxt    = rnd;
                    end
                end
            end
            // frame on air
            TX_SEND: begin
                if (TX_DONE_IN) begin
                    st_nxt = TX_WACK;
                end
            end
            // wait for acknowledgement, retry on timeout below the frame limit unless in immediate mode
            TX_WACK: begin
                if (ACK_RCVD_IN) begin
                    ts_nxt       = TS_SUCCESS;
                    ev[EV_TX_OK] = 1'b1;
                    st_nxt       = TX_IDLE;
                end else if (ACK_TIMEOUT_IN) begin
                    if (bo_lim_r == CSMA_IMMEDIATE || frm_cnt_r >= frm_lim_r) begin
                        ts_nxt         = TS_NO_ACK;
                        ev[EV_TX_FAIL] = 1'b1;
                        st_nxt         = TX_IDLE;
                    end else begin
                        frm_cnt_nxt = 4'(frm_cnt_r + 4'h1);
                        bo_cnt_nxt  = 3'h0;
                        cca_go_nxt  = 1'b1;
                        rnd_nxt     = rnd;
                        st_nxt      = TX_CCA;
                    end
                end
            end
        endcase
        // received frame in auto-ack mode
        if (RX_DONE_IN && mode_r[MODE_RX_BIT]) begin
            if (!version_ok(RX_VERSION_IN, seed_hi_r[FVN_LSB +: 2])) begin
                rej_nxt        = 1'b1;
                ev[EV_REJECT]  = 1'b1;
            end else if (RX_ACK_REQ_IN) begin
                if (limit_r[SLOT_BIT]) begin
                    pend_nxt       = 1'b1;
                    ev[EV_ACK_PND] = 1'b1;
                end else begin
                    ack_go_nxt = 1'b1;
                end
            end
        end else if (pend_r && trig_rise) begin
            ack_go_nxt = 1'b1;
            pend_nxt   = 1'b0;
            ts_nxt     = TS_SUCCESS;
        end
        // pending code shown while waiting for trigger
        if (pend_nxt) begin
            ts_nxt = TS_ACK_PENDING;
        end
    end

    // sequencer registers
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            st_r      <= TX_IDLE;
            frm_cnt_r <= 4'h0;
            bo_cnt_r  <= 3'h0;
            frm_lim_r <= 4'h3;
            bo_lim_r  <= 3'h4;
            pend_r    <= 1'b0;
            ts_r      <= TS_INVALID;
            cca_go_r  <= 1'b0;
            tx_go_r   <= 1'b0;
            ack_go_r  <= 1'b0;
            rej_r     <= 1'b0;
            ackv_r    <= ACK_FVN;
            rnd_r     <= 11'h000;
            pin_lvl_r <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            frm_cnt_r <= frm_cnt_nxt;
            bo_cnt_r  <= bo_cnt_nxt;
            frm_lim_r <= frm_lim_nxt;
            bo_lim_r  <= bo_lim_nxt;
            pend_r    <= pend_nxt;
            ts_r      <= ts_nxt;
            cca_go_r  <= cca_go_nxt;
            tx_go_r   <= tx_go_nxt;
            ack_go_r  <= ack_go_nxt;
            rej_r     <= rej_nxt;
            ackv_r    <= ackv_nxt;
            rnd_r     <= rnd_nxt;
            pin_lvl_r <= pin_lvl_nxt;
        end
    end

    // bus slave: one-cycle answer, writes on lane 0
    always_comb begin
        limit_nxt   = limit_r;
        seed_lo_nxt = seed_lo_r;
        seed_hi_nxt = seed_hi_r;
        mode_nxt    = mode_r;
        irq_mk_nxt  = irq_mk_r;
        irq_st_nxt  = irq_st_r;
        ack_nxt     = req;
        rdat_nxt    = rdat_r;
        if (req && !WB_WE_IN) begin
            // read mux; unmapped reads as zero
            rdat_nxt = 32'h0000_0000;
            unique case (idx)
                IDX_RETRY_COUNT:  rdat_nxt[7:0] = {frm_cnt_r, bo_cnt_r, 1'b0};
                IDX_RETRY_LIMIT:  rdat_nxt[7:0] = limit_r;
                IDX_SEED_LOW:     rdat_nxt[7:0] = seed_lo_r;
                IDX_SEED_HIGH:    rdat_nxt[7:0] = seed_hi_r;
                IDX_MODE:         rdat_nxt[7:0] = mode_r;
                IDX_IRQ_STATUS:   rdat_nxt[EV_W-1:0] = irq_st_r;
                IDX_IRQ_MASK:     rdat_nxt[EV_W-1:0] = irq_mk_r;
                IDX_TRANS_STATUS: rdat_nxt[2:0] = ts_r;
                default:          rdat_nxt = 32'h0000_0000;
            endcase
            // reading status clears it
            if (idx == IDX_IRQ_STATUS) begin
                irq_st_nxt = '0;
            end
        end
        if (req && WB_WE_IN && WB_SEL_IN[0]) begin
            // writes land in shadow; sequencer latches at start
            unique case (idx)
                IDX_RETRY_LIMIT: limit_nxt   = WB_DAT_IN[7:0];
                IDX_SEED_LOW:    seed_lo_nxt = WB_DAT_IN[7:0];
                IDX_SEED_HIGH:   seed_hi_nxt = WB_DAT_IN[7:0];
                IDX_MODE:        mode_nxt    = WB_DAT_IN[7:0];
                IDX_IRQ_MASK:    irq_mk_nxt  = WB_DAT_IN[EV_W-1:0];
                default:         limit_nxt   = limit_r;
            endcase
        end
        // new events win over a clearing read
        irq_st_nxt = irq_st_nxt | ev;
        irq_nxt    = |(irq_st_nxt & irq_mk_nxt);
    end

    // register file flops
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            limit_r   <= RST_RETRY_LIMIT;
            seed_lo_r <= RST_SEED_LOW;
            seed_hi_r <= RST_SEED_HIGH;
            mode_r    <= RST_MODE;
            irq_st_r  <= '0;
            irq_mk_r  <= RST_IRQ_MASK;
            ack_r     <= 1'b0;
            rdat_r    <= 32'h0000_0000;
            irq_r     <= 1'b0;
        end else begin
            limit_r   <= limit_nxt;
            seed_lo_r <= seed_lo_nxt;
            seed_hi_r <= seed_hi_nxt;
            mode_r    <= mode_nxt;
            irq_st_r  <= irq_st_nxt;
            irq_mk_r  <= irq_mk_nxt;
            ack_r     <= ack_nxt;
            rdat_r    <= rdat_nxt;
            irq_r     <= irq_nxt;
        end
    end

    // outputs straight from flops
    assign WB_DAT_OUT             = rdat_r;
    assign WB_ACK_OUT             = ack_r;
    assign CCA_START_OUT          = cca_go_r;
    assign TX_START_OUT           = tx_go_r;
    assign BACKOFF_RAND_OUT       = rnd_r;
    assign ACK_SEND_OUT           = ack_go_r;
    assign ACK_VERSION_OUT        = ackv_r;
    assign RX_REJECT_OUT          = rej_r;
    assign TRANSACTION_STATUS_OUT = ts_r;
    assign IRQ_OUT                = irq_r;
endmodule // mrsf_top

// [test/mrsf_chk.sv]
`timescale 1ns/1ps
module mrsf_chk
    import mrsf_pkg::*;
(
    // clock and reset
    input wire logic       CLK_IN,
    input wire logic       RESET_N_IN,
    // register bus
    input wire logic       WB_CYC_IN,
    input wire logic       WB_STB_IN,
    input wire logic       WB_ACK_OUT,
    // radio side
    input wire logic       TX_REQ_IN,
    input wire logic       CCA_DONE_IN,
    input wire logic       ACK_TIMEOUT_IN,
    input wire logic       RX_DONE_IN,
    input wire logic       RX_ACK_REQ_IN,
    input wire logic       CCA_START_OUT,
    input wire logic       TX_START_OUT,
    input wire logic       ACK_SEND_OUT,
    input wire logic [1:0] ACK_VERSION_OUT,
    input wire logic       RX_REJECT_OUT,
    input wire logic [2:0] TRANSACTION_STATUS_OUT
);
    // one domain, async reset
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    // bus answer one cycle after the request, one cycle long
    property p_ack_lat; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT; endproperty
    property p_ack_pulse; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
    // rejections only follow a received frame
    property p_rej_cause; RX_REJECT_OUT |-> $past(RX_DONE_IN); endproperty
    // ack from a requesting frame or from a pending slot ack
    property p_ack_cause;
        ACK_SEND_OUT |-> $past(RX_DONE_IN && RX_ACK_REQ_IN)
            || $past(TRANSACTION_STATUS_OUT) == TS_ACK_PENDING;
    endproperty
    property p_ack_ver; ACK_SEND_OUT |-> ACK_VERSION_OUT == ACK_FVN; endproperty
    property p_no_both; !(ACK_SEND_OUT && RX_REJECT_OUT); endproperty
    // transmit starts after a clear channel or at once in immediate mode
    property p_tx_cause; TX_START_OUT |-> $past(CCA_DONE_IN) || $past(TX_REQ_IN); endproperty
    property p_cca_cause;
        CCA_START_OUT |-> $past(TX_REQ_IN) || $past(CCA_DONE_IN) || $past(ACK_TIMEOUT_IN)
            || $past(CCA_DONE_IN, 2) || $past(ACK_TIMEOUT_IN, 2);
    endproperty
    // pending code leaves only when the ack goes out
    property p_pend;
        TRANSACTION_STATUS_OUT == TS_ACK_PENDING ##1 TRANSACTION_STATUS_OUT != TS_ACK_PENDING
            |-> ACK_SEND_OUT;
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("bus answer late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("bus answer too long");
    a_rej_cause: assert property (p_rej_cause) else $error("reject w/o frame");
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    a_ack_ver: assert property (p_ack_ver) else $error("ack version nonzero");
    a_no_both: assert property (p_no_both) else $error("rejected frame acked");
    a_tx_cause: assert property (p_tx_cause) else $error("stray transmit");
    a_cca_cause: assert property (p_cca_cause) else $error("stray access");
    a_pend: assert property (p_pend) else $error("pending lost");
    // main scenarios reached
    c_ack: cover property (ACK_SEND_OUT);
    c_rej: cover property (RX_REJECT_OUT);
    c_tx: cover property (TX_START_OUT);
endmodule // mrsf_chk

// [test/mrsf_radio_model.sv]
`timescale 1ns/1ps
module mrsf_radio_model (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    // requests to and from the block
    input  wire logic       tx_req_in,
    input  wire logic       cca_start_in,
    input  wire logic       tx_start_in,
    // behaviour: busy results, missed acks, answer delay (>=1)
    input  wire logic [2:0] busy_in,
    input  wire logic [2:0] nack_in,
    input  wire logic [2:0] dly_in,
    // results back to the block
    output logic            cca_done_out,
    output logic            cca_idle_out,
    output logic            tx_done_out,
    output logic            ack_rcvd_out,
    output logic            ack_timeout_out
);
    int cc, tc, ac, nb, nn;  // wait counters, per-transaction tallies
    // answers each start after dly cycles
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cc = 0; tc = 0; ac = 0; nb = 0; nn = 0;
            {cca_done_out, tx_done_out, ack_rcvd_out, ack_timeout_out} <= 4'h0;
            cca_idle_out <= 1'b0;
        end else begin
            {cca_done_out, tx_done_out, ack_rcvd_out, ack_timeout_out} <= 4'h0;
            cca_idle_out <= ~cca_idle_out;  // meaningless outside a result
            if (tx_req_in) begin nb = 0; nn = 0; end
            if (ac == 1) begin
                if (nn < nack_in) ack_timeout_out <= 1'b1;
                else ack_rcvd_out <= 1'b1;
                nn++;
            end
            if (ac > 0) ac--;
            if (tc == 1) begin tx_done_out <= 1'b1; ac = dly_in + 1; end
            if (tc > 0) tc--;
            if (cc == 1) begin cca_done_out <= 1'b1; cca_idle_out <= (nb >= busy_in); nb++; end
            if (cc > 0) cc--;
            if (cca_start_in) cc = dly_in;
            if (tx_start_in) tc = dly_in;
        end
    end
endmodule // mrsf_radio_model

// [test/mac_retry_seed_filter_config_test.sv]
`timescale 1ns/1ps
module mac_retry_seed_filter_config_test;
    import mrsf_pkg::*;
    logic        clk, rst_n, cyc, stb, we, ack, pin, wake, irq;  // bus, pins
    logic [7:0]  adr;
    logic [31:0] dat, rdat;
    logic        tx_req, cca_done, cca_idle, tx_done, ack_rcvd, ack_to, cca_st, tx_st;
    logic [10:0] rnd, sd;
    logic        rx_done, rx_req, ack_send, rej;  // receive side
    logic [1:0]  rx_ver, ack_ver;
    logic [2:0]  ts, busy, nack, dly;
    int          errors, n_tests, seed;
    logic [5:0]  t_idx [6] = '{IDX_RETRY_LIMIT, IDX_SEED_LOW, IDX_SEED_HIGH, IDX_TRANS_STATUS,
                               IDX_RETRY_COUNT, 6'h01};
    logic [7:0]  t_rst [6] = '{{4'h3, 3'h4, 1'b0}, 8'hea, {2'h1, 3'h0, 3'h2}, 8'h07, 8'h00, 8'h00};

    mrsf_top u_dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'h1), .WB_DAT_IN(dat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .SLEEP_TX_TRIGGER_PIN_IN(pin), .TX_REQ_IN(tx_req),
        .CCA_DONE_IN(cca_done), .CCA_IDLE_IN(cca_idle), .TX_DONE_IN(tx_done),
        .ACK_RCVD_IN(ack_rcvd), .ACK_TIMEOUT_IN(ack_to), .DEEP_WAKE_IN(wake),
        .CCA_START_OUT(cca_st), .TX_START_OUT(tx_st), .BACKOFF_RAND_OUT(rnd),
        .RX_DONE_IN(rx_done), .RX_VERSION_IN(rx_ver), .RX_ACK_REQ_IN(rx_req),
        .ACK_SEND_OUT(ack_send), .ACK_VERSION_OUT(ack_ver), .RX_REJECT_OUT(rej),
        .TRANSACTION_STATUS_OUT(ts), .IRQ_OUT(irq));
    mrsf_radio_model u_radio (.clk_in(clk), .reset_n_in(rst_n), .tx_req_in(tx_req),
        .cca_start_in(cca_st), .tx_start_in(tx_st), .busy_in(busy), .nack_in(nack),
        .dly_in(dly), .cca_done_out(cca_done), .cca_idle_out(cca_idle), .tx_done_out(tx_done),
        .ack_rcvd_out(ack_rcvd), .ack_timeout_out(ack_to));

    // free-running 100 MHz clock
    initial begin clk = 1'b0; forever #5 clk = ~clk; end

    task automatic chk(input logic [10:0] g, input logic [10:0] e);
        n_tests++;
        if (g !== e) begin errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end
    endtask
    // classic single bus cycle, waits for the answer
    task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d,
                      output logic [7:0] q);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {i, 2'b00}; dat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    // expected outcome of one transmit transaction
    function automatic logic [2:0] exp_ts(input logic [3:0] f, input logic [2:0] b,
                                          input logic [2:0] nb, input logic [2:0] nk);
        if (b == CSMA_IMMEDIATE) return (nk > 0) ? TS_NO_ACK : TS_SUCCESS;
        if (nb > b) return TS_ACCESS_FAIL;
        return (nk > f) ? TS_NO_ACK : TS_SUCCESS;
    endfunction
    task automatic tx(input logic [3:0] f, input logic [2:0] b, input logic [2:0] nb,
                      input logic [2:0] nk);
        logic [7:0] q;
        wb(1'b1, IDX_RETRY_LIMIT, {f, b, 1'b0}, q);
        wb(1'b0, IDX_RETRY_LIMIT, 8'h00, q);
        chk(q, {f, b, 1'b0});
        wb(1'b0, IDX_IRQ_STATUS, 8'h00, q);
        busy <= nb; nack <= nk;
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) {wake, tx_req} <= 2'b01;
        @(posedge clk) tx_req <= 1'b0;
        @(posedge clk) if (b != CSMA_IMMEDIATE) chk(rnd, sd ? sd : 11'h001);
        while (irq !== 1'b1) @(posedge clk);
        chk(ts, exp_ts(f, b, nb, nk));
        wb(1'b0, IDX_IRQ_STATUS, 8'h00, q);
        chk(q[1:0], (exp_ts(f, b, nb, nk) == TS_SUCCESS) ? 2'h1 : 2'h2);
        wb(1'b0, IDX_RETRY_COUNT, 8'h00, q);
        chk(q, b == CSMA_IMMEDIATE ? 8'h0 : {nk > f ? f : nk, nb > b ? b : nb, 1'b0});
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
    endtask
    task automatic rx(input logic [1:0] v, input logic rq, output logic a, output logic j);
        @(posedge clk);
        rx_done <= 1'b1; rx_ver <= v; rx_req <= rq;
        @(posedge clk);
        rx_done <= 1'b0; rx_ver <= ~v; rx_req <= ~rq;
        @(posedge clk);
        a = ack_send;
        j = rej;
        chk(ack_ver, ACK_FVN);
    endtask
    task automatic report_and_stop;
        if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard
    initial begin #600000; errors++; report_and_stop; end

    initial begin
        logic [7:0] q;
        logic       a, j;
        logic [2:0] b;
        int         r, n;
        seed = 32813; errors = 0; n_tests = 0;
        {cyc, stb, we, pin, tx_req, rx_done, rx_req, wake} = 8'h00;
        adr = 8'h00; dat = 32'h0; rx_ver = 2'h0; busy = 3'h0; nack = 3'h0; dly = 3'h1;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // read-only and unmapped writes are dropped
        wb(1'b1, IDX_TRANS_STATUS, 8'hff, q);
        wb(1'b1, 6'h01, 8'hff, q);
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, t_idx[i], 8'h00, q);
            chk(q, t_rst[i]);
        end
        r = $random(seed);
        sd = r[10:0];
        wb(1'b1, IDX_SEED_LOW, r[7:0], q);
        wb(1'b1, IDX_SEED_HIGH, r[15:8], q);
        wb(1'b0, IDX_SEED_LOW, 8'h00, q);
        chk(q, r[7:0]);
        wb(1'b0, IDX_SEED_HIGH, 8'h00, q);
        chk(q, r[15:8]);
        wb(1'b1, IDX_MODE, 8'h03, q);
        wb(1'b1, IDX_IRQ_MASK, 8'h03, q);
        // corners, then random transactions
        tx(4'h0, 3'h0, 3'h1, 3'h0);
        tx(4'h0, 3'h7, 3'h3, 3'h1);
        tx(4'h0, 3'h2, 3'h0, 3'h1);
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            b = (r[4:2] == 3'h6) ? 3'h5 : r[4:2];
            dly <= {1'b0, r[9:8]} + 3'h1;
            if (r[5]) tx({2'h0, r[1:0]}, b, {1'b0, r[7:6]}, 3'h0);
            else tx({2'h0, r[1:0]}, b, 3'h0, {1'b0, r[7:6]});
        end
        // version filter, every limit against every version
        for (int fv = 0; fv < 4; fv++) begin
            wb(1'b1, IDX_SEED_HIGH, {fv[1:0], 6'h02}, q);
            for (int v = 0; v < 4; v++) begin
                rx(v[1:0], 1'b1, a, j);
                chk(a, v <= fv);
                chk(j, v > fv);
            end
        end
        rx(2'h0, 1'b0, a, j);
        chk(a, 1'b0);
        // slot-aligned ack waits for the trigger pin
        wb(1'b1, IDX_RETRY_LIMIT, 8'h39, q);
        rx(2'h1, 1'b1, a, j);
        chk(a, 1'b0);
        chk(ts, TS_ACK_PENDING);
        @(posedge clk) pin <= 1'b1;
        n = 0;
        a = 1'b0;
        while (a !== 1'b1 && n < 20) begin @(posedge clk); a = ack_send; n++; end
        chk(a, 1'b1);
        chk(ack_ver, ACK_FVN);
        @(posedge clk) pin <= 1'b0;
        chk(ts, TS_SUCCESS);
        report_and_stop;
    end
endmodule // mac_retry_seed_filter_config_test

bind mrsf_top mrsf_chk u_chk (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
    .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT),
    .TX_REQ_IN(TX_REQ_IN), .CCA_DONE_IN(CCA_DONE_IN), .ACK_TIMEOUT_IN(ACK_TIMEOUT_IN),
    .RX_DONE_IN(RX_DONE_IN), .RX_ACK_REQ_IN(RX_ACK_REQ_IN), .CCA_START_OUT(CCA_START_OUT),
    .TX_START_OUT(TX_START_OUT), .ACK_SEND_OUT(ACK_SEND_OUT),
    .ACK_VERSION_OUT(ACK_VERSION_OUT), .RX_REJECT_OUT(RX_REJECT_OUT),
    .TRANSACTION_STATUS_OUT(TRANSACTION_STATUS_OUT));
